// *** sim/sdcb_core_monitor.sv ***
`timescale 1ns/10ps
module sdcb_core_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic dq_oe,
	input sdcb_pkg::sdcb_bank_st_t bank_state [4],
	input wire logic [3:0] bank_idle,
	input wire logic wdata_overrun
);
	import sdcb_pkg::*;
	logic [3:0] idle_exp;
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			idle_exp[b] = bank_state[b] == SDCB_ST_IDLE;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence pre_hold;
		(bank_state[0] == SDCB_ST_PRECHARGING) [*3];
	endsequence
	sequence act_hold;
		(bank_state[0] == SDCB_ST_ACTIVATING) [*3];
	endsequence
	idle_decode_a: assert property (bank_idle == idle_exp)
		else $error("idle flags disagree with bank states");
	reset_values_a: assert property (disable iff (1'b0) rst |=>
		!dq_oe && bank_idle == 4'hf && !wdata_overrun)
		else $error("outputs not at reset values");
	pre_to_idle_a: assert property ($rose(bank_state[0] == SDCB_ST_PRECHARGING) |->
		pre_hold ##[1:4] bank_state[0] == SDCB_ST_IDLE)
		else $error("precharge length wrong");
	act_to_active_a: assert property ($rose(bank_state[0] == SDCB_ST_ACTIVATING) |->
		act_hold ##[1:4] bank_state[0] == SDCB_ST_ACTIVE)
		else $error("activate length wrong");
	rap_exit_a: assert property (bank_state[0] == SDCB_ST_READ_AP ##1
		bank_state[0] != SDCB_ST_READ_AP |-> bank_state[0] == SDCB_ST_IDLE)
		else $error("read with precharge did not end idle");
	wap_exit_a: assert property (bank_state[0] == SDCB_ST_WRITE_AP ##1
		bank_state[0] != SDCB_ST_WRITE_AP |-> bank_state[0] == SDCB_ST_IDLE)
		else $error("write with precharge did not end idle");
	overrun_sticky_a: assert property (wdata_overrun |=> wdata_overrun)
		else $error("overrun flag cleared");
	// Commands reach the state two flops late, so look back two to four samples
	inhibit_guard_a: assert property ($fell(bank_idle[0]) |->
		!$past(cs_n, 2) || !$past(cs_n, 3) || !$past(cs_n, 4))
		else $error("bank left idle without a selected command");
endmodule

bind sdcb_core sdcb_core_monitor u_mon (
	.clk(clk),
	.rst(rst),
	.cs_n(cs_n),
	.dq_oe(dq_oe),
	.bank_state(bank_state),
	.bank_idle(bank_idle),
	.wdata_overrun(wdata_overrun)
);

// *** sim/sdcb_ctrl_model.sv ***
`timescale 1ns/10ps
`include "sdcb_params.svh"
module sdcb_ctrl_model (
	input wire logic clk,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [1:0] ba,
	output logic [11:0] addr,
	output logic [1:0] dqm,
	output logic [15:0] dq_in
);
	initial begin
		cke = 1'b1;
		{cs_n, ras_n, cas_n, we_n} = `SDCB_CMD_NOP;
		ba = 2'h0;
		addr = 12'h000;
		dqm = 2'h3;
		dq_in = 16'h0000;
	end
	// Entered just after a falling edge, so pins hold through the next rising edge
	task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic [15:0] d);
		{cs_n, ras_n, cas_n, we_n} = c;
		ba = b;
		addr = a;
		dq_in = d;
		dqm = 2'h0;
		@(negedge clk);
	endtask
	task automatic beat(input logic [15:0] d, input logic [1:0] mk = 2'h0);
		{cs_n, ras_n, cas_n, we_n} = `SDCB_CMD_NOP;
		dq_in = d;
		dqm = mk;
		@(negedge clk);
	endtask
	// Idle lanes stay masked so a later write never meets read data
	task automatic nop(input int n);
		{cs_n, ras_n, cas_n, we_n} = `SDCB_CMD_NOP;
		dqm = 2'h3;
		dq_in = ~dq_in;
		repeat (n) @(negedge clk);
	endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/10ps
`include "sdcb_params.svh"
module tb;
	import sdcb_pkg::*;
	logic clk, rst, cke, cs_n, ras_n, cas_n, we_n, dq_oe, wdata_overrun;
	logic [1:0] ba, dqm;
	logic [11:0] addr;
	logic [15:0] dq_in, dq_out;
	logic [3:0] bank_idle;
	sdcb_bank_st_t bank_state [4];
	logic [15:0] q [$];
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	int lat, span;
	sdcb_ctrl_model m (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in));
	sdcb_core dut (.clk(clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .bank_state(bank_state), .bank_idle(bank_idle),
		.wdata_overrun(wdata_overrun));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic finish_test;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			n_errors++;
			finish_test();
		end
	end
	task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", s, exp, seen);
			n_errors++;
		end
	endtask
	task automatic act(input logic [1:0] b);
		m.cmd(`SDCB_CMD_ACT, b, 12'h000, ~dq_in);
	endtask
	task automatic rd(input logic [1:0] b, input logic [3:0] c, input logic ap);
		m.cmd(`SDCB_CMD_RD, b, {1'b0, ap, 6'h00, c}, ~dq_in);
	endtask
	task automatic wr(input logic [1:0] b, input logic [3:0] c, input logic ap,
		input logic [15:0] d, input int n, input logic [1:0] mk = 2'h0);
		m.cmd(`SDCB_CMD_WR, b, {1'b0, ap, 6'h00, c}, d);
		// Lanes masked on the following words keep their old bytes
		for (int i = 1; i < n; i++) begin
			m.beat(d + 16'(i), mk);
		end
	endtask
	task automatic wst(input int b, input sdcb_bank_st_t s, input int lim);
		int k;
		k = 0;
		m.nop(0);
		while (bank_state[b] !== s && k < lim) begin
			@(negedge clk);
			k++;
		end
		chk("bank state", 16'(bank_state[b]), 16'(s));
	endtask
	// Gaps between words are allowed here; span reveals them
	task automatic grab(input int n);
		int k;
		k = 0;
		q.delete();
		m.nop(0);
		while (q.size() < n && k < 30) begin
			if (dq_oe === 1'b1) begin
				// Shown here, taken by the controller at the next rising edge
				if (q.size() == 0)
					lat = k + 1;
				q.push_back(dq_out);
			end
			@(negedge clk);
			k++;
		end
		span = k - lat + 1;
	endtask
	task automatic t_basic;
		act(2'h0);
		act(2'h1);
		wst(0, SDCB_ST_ACTIVE, 8);
		wr(2'h0, 4'h0, 1'b0, 16'h1000, 4);
		wr(2'h1, 4'h0, 1'b0, 16'h2000, 4);
		m.nop(8);
		rd(2'h0, 4'h0, 1'b0);
		grab(4);
		chk("read latency", 16'(lat), 16'h0005);
		for (int i = 0; i < 4; i++) begin
			chk("read word", q[i], 16'h1000 + 16'(i));
		end
		$display("t_basic done");
	endtask
	task automatic t_rr(input logic ap);
		rd(2'h0, 4'h0, ap);
		rd(2'h1, 4'h0, 1'b0);
		grab(5);
		chk("first word", q[0], 16'h1000);
		for (int i = 1; i < 5; i++) begin
			chk("next word", q[i], 16'h2000 + 16'(i - 1));
		end
		chk("span", 16'(span), 16'h0005);
		if (ap)
			wst(0, SDCB_ST_IDLE, 12);
		$display("t_rr done");
	endtask
	task automatic t_pre;
		act(2'h0);
		wst(0, SDCB_ST_ACTIVE, 8);
		rd(2'h0, 4'h0, 1'b0);
		m.cmd(`SDCB_CMD_PRE, 2'h1, 12'h000, ~dq_in);
		grab(4);
		for (int i = 0; i < 4; i++) begin
			chk("kept word", q[i], 16'h1000 + 16'(i));
		end
		wst(1, SDCB_ST_IDLE, 10);
		$display("t_pre done");
	endtask
	task automatic t_ww;
		act(2'h1);
		wst(1, SDCB_ST_ACTIVE, 8);
		wr(2'h0, 4'h4, 1'b1, 16'h3000, 2);
		wr(2'h1, 4'h4, 1'b0, 16'h4000, 4);
		wst(0, SDCB_ST_IDLE, 16);
		m.nop(8);
		act(2'h0);
		wst(0, SDCB_ST_ACTIVE, 8);
		rd(2'h0, 4'h4, 1'b0);
		grab(2);
		chk("cut word 0", q[0], 16'h3000);
		chk("cut word 1", q[1], 16'h3001);
		m.nop(4);
		rd(2'h1, 4'h4, 1'b0);
		grab(4);
		for (int i = 0; i < 4; i++) begin
			chk("new bank word", q[i], 16'h4000 + 16'(i));
		end
		$display("t_ww done");
	endtask
	task automatic t_inhibit;
		m.cmd(4'hb, 2'h2, 12'h000, ~dq_in);
		m.cke = 1'b0;
		act(2'h3);
		m.cke = 1'b1;
		m.nop(8);
		chk("idle banks", 16'(bank_idle[3:2]), 16'h0003);
		$display("t_inhibit done");
	endtask
	// The buffer must drain before the read, so a gap follows the write
	task automatic t_misc;
		wr(2'h0, 4'h0, 1'b0, 16'h5010, 4, 2'h2);
		m.nop(4);
		rd(2'h0, 4'h0, 1'b0);
		grab(4);
		chk("masked word 0", q[0], 16'h5010);
		for (int i = 1; i < 4; i++) begin
			chk("masked word", q[i], 16'h1010 + 16'(i));
		end
		rd(2'h0, 4'h0, 1'b0);
		m.nop(1);
		m.cmd(`SDCB_CMD_BST, 2'h0, 12'h000, ~dq_in);
		grab(3);
		chk("stopped burst", 16'(q.size()), 16'h0002);
		chk("last word", q[1], 16'h1011);
		m.cmd(`SDCB_CMD_PRE, 2'h0, 12'h400, ~dq_in);
		wst(0, SDCB_ST_IDLE, 10);
		chk("all idle", 16'(bank_idle), 16'h000f);
		m.cke = 1'b0;
		m.cmd(`SDCB_CMD_REF, 2'h0, 12'h000, ~dq_in);
		m.nop(3);
		m.cke = 1'b1;
		m.nop(2);
		act(2'h3);
		m.nop(4);
		chk("exit window", 16'(bank_idle[3]), 16'h0001);
		m.nop(16);
		act(2'h3);
		wst(3, SDCB_ST_ACTIVE, 8);
		$display("t_misc done");
	endtask
	initial begin
		rst = 1'b1;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		// Synchroniser and clock gate history restart from zero after reset
		m.nop(2);
		t_basic();
		t_rr(1'b0);
		t_rr(1'b1);
		t_pre();
		t_ww();
		t_inhibit();
		t_misc();
		chk("overrun", 16'(wdata_overrun), 16'h0000);
		finish_test();
	end
endmodule

// *** src/sdcb_core.sv ***
// Functional notes
// - Chip select high is an inhibit; nothing new starts, current work continues.
// - NOP: chip select low, other strobes high; current operation continues.
// - Commands count only with clock gate high twice and self-refresh exit done.
// - Activate, read, write and precharge use the fixed four-strobe codes.
// - A bank is idle only after precharge and full row precharge time.
// - A bank is row active once activate-to-column delay passes, no burst running.
// - Read with auto precharge holds its state until row precharge time, then idle.
// - Write with auto precharge holds its state for write recovery plus row precharge time, then idle.
// - Burst terminate acts on the running burst only, never another bank.
// - Reads and writes to another bank may carry auto precharge or not.
// - An interrupted auto-precharge burst starts its own precharge.
// - Precharge to another bank leaves the running burst untouched.
// - Read interrupting read takes the bus one read latency later, back to back.
// - Write ends a plain read on registration; data mask one clock earlier.
// - Read ends a write on registration; last write word is the one before.
// - Write ends a plain write on registration; data then goes to the new bank.
// - Read interrupting a read with auto precharge starts its precharge at once.
// - Write interrupting a read with auto precharge starts its precharge at once.
// - Read interrupting a write with auto precharge: precharge after write recovery.
// - Write interrupting a write with auto precharge: precharge after write recovery.
// - Burst terminate stops the most recent burst, whatever its bank.
// - A precharging bank stays so for row precharge time, then idles.
`timescale 1ns/10ps
`include "sdcb_params.svh"
module sdcb_core #(
	parameter int DW = 16,
	parameter int COL_W = 4,
	parameter int BURST_LEN = 4,
	parameter int READ_LAT = 3,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] ba,
	input wire logic [11:0] addr,
	input wire logic [DW/8-1:0] dqm,
	input wire logic [DW-1:0] dq_in,
	output logic [DW-1:0] dq_out,
	output logic dq_oe,
	output sdcb_pkg::sdcb_bank_st_t bank_state [4],
	output logic [3:0] bank_idle,
	output logic wdata_overrun
);
	import sdcb_pkg::*;

	localparam int LANES = DW / 8;
	localparam int SW = 1 + 4 + 2 + 12 + DW + LANES;
	localparam int FW = 2 + COL_W + DW + LANES;
	localparam sdcb_cnt_t TRP_CYC = sdcb_cnt_t'(`SDCB_CYC(`SDCB_TRP_NS));
	localparam sdcb_cnt_t ACTIVATE_TO_COLUMN_DELAY_CYC = sdcb_cnt_t'(`SDCB_CYC(`SDCB_ACTIVATE_TO_COLUMN_DELAY_NS));
	localparam sdcb_cnt_t TWR_CYC = sdcb_cnt_t'(`SDCB_CYC(`SDCB_TWR_NS));
	localparam sdcb_cnt_t SELF_REFRESH_EXIT_TIME_CYC = sdcb_cnt_t'(`SDCB_CYC(`SDCB_SELF_REFRESH_EXIT_TIME_NS));
	localparam logic [7:0] BL = 8'(BURST_LEN);

	function automatic int unsigned mem_idx(input logic [1:0] b, input logic [COL_W-1:0] c);
		mem_idx = 32'({b, c});
	endfunction

	function automatic logic bank_hit(input logic [1:0] b, input logic [1:0] sel,
		input logic all);
		bank_hit = all || (b == sel);
	endfunction

	// Pin synchroniser, first stage feeds only the second
	logic [SW-1:0] sync1_reg;
	logic [SW-1:0] sync2_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_in};
			sync2_reg <= sync1_reg;
		end
	end

	logic cke_s;
	logic [3:0] cmd;
	logic [1:0] ba_s;
	logic [11:0] addr_s;
	logic [LANES-1:0] dqm_s;
	logic [DW-1:0] dq_s;

	assign {cke_s, cmd, ba_s, addr_s, dqm_s, dq_s} = sync2_reg;

	// Clock gate, self refresh and exit window
	logic cke_prev_reg;
	logic self_ref_reg;
	sdcb_cnt_t xsr_cnt_reg;
	logic ck_ok;
	logic cmd_ok;

	assign ck_ok = cke_prev_reg && cke_s;
	assign cmd_ok = ck_ok && !self_ref_reg && (xsr_cnt_reg == '0) && !cmd[3];

	always_ff @(posedge clk) begin
		if (rst) begin
			cke_prev_reg <= 1'b0;
			self_ref_reg <= 1'b0;
			xsr_cnt_reg <= `SDCB_XSR_RST;
		end else begin
			cke_prev_reg <= cke_s;
			if (!self_ref_reg && cke_prev_reg && !cke_s && (cmd == `SDCB_CMD_REF)) begin
				self_ref_reg <= 1'b1;
			end else if (self_ref_reg && cke_s) begin
				self_ref_reg <= 1'b0;
				xsr_cnt_reg <= SELF_REFRESH_EXIT_TIME_CYC;
			end else if (xsr_cnt_reg != '0) begin
				xsr_cnt_reg <= xsr_cnt_reg - 8'h01;
			end
		end
	end

	// Command decode; NOP, inhibit, refresh and mode load start no bank action
	logic is_act;
	logic is_rd;
	logic is_wr;
	logic is_pre;
	logic is_bst;
	logic is_rdwr;
	logic ap_s;

	assign is_act = cmd_ok && (cmd == `SDCB_CMD_ACT);
	assign is_rd = cmd_ok && (cmd == `SDCB_CMD_RD);
	assign is_wr = cmd_ok && (cmd == `SDCB_CMD_WR);
	assign is_pre = cmd_ok && (cmd == `SDCB_CMD_PRE);
	assign is_bst = cmd_ok && (cmd == `SDCB_CMD_BST);
	assign is_rdwr = is_rd || is_wr;
	assign ap_s = addr_s[`SDCB_AP_BIT];

	// Burst engine: one data bus, so one running burst at a time
	logic bst_act_reg;
	logic bst_wr_reg;
	logic [1:0] bst_bank_reg;
	logic [COL_W-1:0] bst_col_reg;
	logic [7:0] bst_left_reg;
	logic pre_hits_burst;
	logic keep_going;
	logic end_old;
	logic xfer_en;
	logic xfer_wr;
	logic [1:0] xfer_bank;
	logic [COL_W-1:0] xfer_col;

	assign pre_hits_burst = is_pre && bank_hit(bst_bank_reg, ba_s, addr_s[`SDCB_AP_BIT]);
	// Precharge elsewhere does not stop the burst; terminate stops whatever runs
	assign keep_going = bst_act_reg && ck_ok && !is_rdwr && !is_bst && !pre_hits_burst;
	assign end_old = bst_act_reg && (is_rdwr || is_bst || pre_hits_burst ||
		(keep_going && bst_left_reg == 8'h01));
	assign xfer_en = is_rdwr || keep_going;
	assign xfer_wr = is_rdwr ? is_wr : bst_wr_reg;
	assign xfer_bank = is_rdwr ? ba_s : bst_bank_reg;
	assign xfer_col = is_rdwr ? addr_s[COL_W-1:0] : bst_col_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			bst_act_reg <= 1'b0;
			bst_wr_reg <= 1'b0;
			bst_bank_reg <= 2'h0;
			bst_col_reg <= '0;
			bst_left_reg <= 8'h00;
		end else if (is_rdwr) begin
			// New burst takes over at once; the old one ends here
			bst_act_reg <= BL > 8'h01;
			bst_wr_reg <= is_wr;
			bst_bank_reg <= ba_s;
			bst_col_reg <= xfer_col + COL_W'(1);
			bst_left_reg <= BL - 8'h01;
		end else if (end_old) begin
			bst_act_reg <= 1'b0;
		end else if (keep_going) begin
			bst_col_reg <= bst_col_reg + COL_W'(1);
			bst_left_reg <= bst_left_reg - 8'h01;
		end
	end

	// Bank state machines
	sdcb_bank_st_t st_reg [4];
	sdcb_cnt_t cnt_reg [4];
	logic [3:0] hold_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int b = 0; b < 4; b++) begin
				st_reg[b] <= SDCB_ST_IDLE;
				cnt_reg[b] <= `SDCB_CNT_RST;
				hold_reg[b] <= 1'b0;
			end
		end else begin
			for (int b = 0; b < 4; b++) begin
				if (is_act && ba_s == 2'(b)) begin
					st_reg[b] <= SDCB_ST_ACTIVATING;
					cnt_reg[b] <= ACTIVATE_TO_COLUMN_DELAY_CYC;
				end else if (is_rdwr && ba_s == 2'(b)) begin
					hold_reg[b] <= 1'b1;
					cnt_reg[b] <= `SDCB_CNT_RST;
					if (is_rd) begin
						st_reg[b] <= ap_s ? SDCB_ST_READ_AP : SDCB_ST_READ;
					end else begin
						st_reg[b] <= ap_s ? SDCB_ST_WRITE_AP : SDCB_ST_WRITE;
					end
				end else if (is_pre && bank_hit(2'(b), ba_s, addr_s[`SDCB_AP_BIT])) begin
					st_reg[b] <= SDCB_ST_PRECHARGING;
					cnt_reg[b] <= TRP_CYC;
					hold_reg[b] <= 1'b0;
				end else if (end_old && bst_bank_reg == 2'(b) && hold_reg[b]) begin
					// Burst in this bank stopped by another bank's burst, by burst terminate or by its end
					hold_reg[b] <= 1'b0;
					unique case (st_reg[b])
						SDCB_ST_READ, SDCB_ST_WRITE: st_reg[b] <= SDCB_ST_ACTIVE;
						SDCB_ST_READ_AP: cnt_reg[b] <= TRP_CYC;
						SDCB_ST_WRITE_AP: cnt_reg[b] <= TWR_CYC + TRP_CYC;
						default: st_reg[b] <= st_reg[b];
					endcase
				end else if (cnt_reg[b] != '0 && !hold_reg[b]) begin
					cnt_reg[b] <= cnt_reg[b] - 8'h01;
					if (cnt_reg[b] == 8'h01) begin
						unique case (st_reg[b])
							SDCB_ST_ACTIVATING: st_reg[b] <= SDCB_ST_ACTIVE;
							SDCB_ST_PRECHARGING: st_reg[b] <= SDCB_ST_IDLE;
							SDCB_ST_READ_AP: st_reg[b] <= SDCB_ST_IDLE;
							SDCB_ST_WRITE_AP: st_reg[b] <= SDCB_ST_IDLE;
							default: st_reg[b] <= st_reg[b];
						endcase
					end
				end
			end
		end
	end

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			bank_state[b] = st_reg[b];
			bank_idle[b] = st_reg[b] == SDCB_ST_IDLE;
		end
	end

	// Storage and write path through the buffer
	logic [DW-1:0] mem_reg [4 << COL_W];
	logic cap_wr;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [FW-1:0] fifo_out_data;
	logic [1:0] drain_bank;
	logic [COL_W-1:0] drain_col;
	logic [DW-1:0] drain_data;
	logic [LANES-1:0] drain_mask;
	logic rd_fetch;

	// The word on the pins with the interrupting read is never written
	assign cap_wr = xfer_en && xfer_wr;
	assign rd_fetch = xfer_en && !xfer_wr;
	// Single-ported array: reads win, so buffered writes wait through every cycle that a read fetches
	assign fifo_out_ready = !rd_fetch;
	assign {drain_bank, drain_col, drain_data, drain_mask} = fifo_out_data;

	sdcb_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_wfifo (
		.clk(clk),
		.rst(rst),
		.in_valid(cap_wr),
		.in_ready(fifo_in_ready),
		.in_data({xfer_bank, xfer_col, dq_s, dqm_s}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	always_ff @(posedge clk) begin
		if (fifo_out_valid && fifo_out_ready) begin
			for (int l = 0; l < LANES; l++) begin
				if (!drain_mask[l]) begin
					mem_reg[mem_idx(drain_bank, drain_col)][l*8 +: 8] <= drain_data[l*8 +: 8];
				end
			end
		end
	end

	// The pins cannot be stalled, so a full buffer drops the word and says so
	always_ff @(posedge clk) begin
		if (rst) begin
			wdata_overrun <= 1'b0;
		end else if (cap_wr && !fifo_in_ready) begin
			wdata_overrun <= 1'b1;
		end
	end

	// Read latency pipeline
	logic [DW-1:0] pipe_data_reg [READ_LAT];
	logic [READ_LAT-1:0] pipe_vld_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			pipe_vld_reg <= '0;
			for (int i = 0; i < READ_LAT; i++) begin
				pipe_data_reg[i] <= '0;
			end
		end else begin
			pipe_data_reg[0] <= mem_reg[mem_idx(xfer_bank, xfer_col)];
			pipe_vld_reg[0] <= rd_fetch;
			for (int i = 1; i < READ_LAT; i++) begin
				pipe_data_reg[i] <= pipe_data_reg[i-1];
				pipe_vld_reg[i] <= pipe_vld_reg[i-1];
			end
			if (is_wr) begin
				// Read words still in flight are dropped so the bus turns round
				pipe_vld_reg <= '0;
			end
		end
	end

	assign dq_out = pipe_data_reg[READ_LAT-1];
	assign dq_oe = pipe_vld_reg[READ_LAT-1];

endmodule

// *** src/sdcb_fifo.sv ***
`timescale 1ns/10ps
module sdcb_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	import sdcb_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic push;
	logic pop;

	// Extra pointer bit tells full from empty
	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
			end
		end
	end

endmodule

// *** src/sdcb_params.svh ***
`ifndef SDCB_PARAMS_SVH
`define SDCB_PARAMS_SVH

// Clock rate and timing figures in their own units
`define SDCB_CLK_MHZ 200
`define SDCB_TRP_NS 20
`define SDCB_ACTIVATE_TO_COLUMN_DELAY_NS 20
`define SDCB_TWR_NS 15
`define SDCB_SELF_REFRESH_EXIT_TIME_NS 70

// Least times round up to whole cycles, never below one
`define SDCB_CYC(ns) ((((ns) * `SDCB_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
	(((ns) * `SDCB_CLK_MHZ + 999) / 1000))

// Command codes as {chip select, row strobe, column strobe, write strobe}
`define SDCB_CMD_LMR 4'h0
`define SDCB_CMD_REF 4'h1
`define SDCB_CMD_PRE 4'h2
`define SDCB_CMD_ACT 4'h3
`define SDCB_CMD_WR 4'h4
`define SDCB_CMD_RD 4'h5
`define SDCB_CMD_BST 4'h6
`define SDCB_CMD_NOP 4'h7

// Address bit that selects auto precharge or precharge of all banks
`define SDCB_AP_BIT 10

// Reset values
`define SDCB_CNT_RST 8'h00
`define SDCB_XSR_RST 8'h00

`endif

// *** src/sdcb_pkg.sv ***
package sdcb_pkg;

	typedef enum logic [2:0] {
		SDCB_ST_IDLE = 3'b000,
		SDCB_ST_ACTIVATING = 3'b001,
		SDCB_ST_ACTIVE = 3'b010,
		SDCB_ST_READ = 3'b011,
		SDCB_ST_WRITE = 3'b100,
		SDCB_ST_READ_AP = 3'b101,
		SDCB_ST_WRITE_AP = 3'b110,
		SDCB_ST_PRECHARGING = 3'b111
	} sdcb_bank_st_t;

	typedef logic [7:0] sdcb_cnt_t;

endpackage
